// ===== rtl/apdb_pkg.sv
// package for the packet doorbell bridge: register offsets, fields, reset values, fis layouts
// assumes a plain address/strobe register port and a host-facing fis request/acknowledge port
package apdb_pkg;

    // ****************************************************************
    // register map (word addresses on the plain register port)
    // ****************************************************************
    localparam logic [3:0] ADDR_TARGET_DOORBELL = 4'h0;
    localparam logic [3:0] ADDR_PROCESSOR_DOORBELL = 4'h1;
    localparam logic [3:0] ADDR_TARGET_CHUNK_LENGTH = 4'h2;
    localparam logic [3:0] ADDR_PROCESSOR_CHUNK_LENGTH = 4'h3;
    localparam logic [3:0] ADDR_CHUNK_ATTRIBUTES = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam logic [3:0] ADDR_HOST_BYTE_LIMIT = 4'h7;
    localparam logic [3:0] ADDR_BRIDGE_STATE = 4'h8;

    // ****************************************************************
    // doorbell bit positions
    // ****************************************************************
    localparam int DB_PACKET_BIT = 0;
    localparam int DB_READ_BIT = 4;

    // ****************************************************************
    // chunk attribute codes
    // ****************************************************************
    localparam logic [1:0] ATTR_LAST_IN = 2'h3;
    localparam logic [1:0] ATTR_MORE_IN = 2'h1;

    // ****************************************************************
    // byte limit thresholds and chunk lengths
    // ****************************************************************
    localparam logic [15:0] LIMIT_LARGE = 16'h0400;
    localparam logic [15:0] LIMIT_SMALL = 16'h0200;
    localparam logic [7:0] CHUNK_LEN_FULL = 8'h00;
    localparam logic [7:0] CHUNK_LEN_HALF = 8'h80;
    localparam logic [15:0] CDB_BYTE_COUNT = 16'h000C;

    // ****************************************************************
    // ata status bits
    // ****************************************************************
    localparam logic [7:0] ST_BSY = 8'h80;
    localparam logic [7:0] ST_DRDY = 8'h40;
    localparam logic [7:0] ST_DRQ = 8'h08;
    localparam logic [7:0] ST_ERR = 8'h01;
    localparam logic [7:0] ERROR_NONE = 8'h00;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] DOORBELL_RESET = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        FIS_PIO_SETUP = 2'h1,
        FIS_REG_D2H = 2'h2
    } apdb_fis_kind_t;

    // fis request toward the stp target
    typedef struct packed {
        apdb_fis_kind_t kind;
        logic dir_in;
        logic irq;
        logic [7:0] initial_status;
        logic [7:0] ending_status;
        logic [7:0] error;
        logic [15:0] pio_byte_count;
    } apdb_fis_t;

    // issued ata command from the host
    typedef struct packed {
        logic [7:0] cyl_high;
        logic [7:0] cyl_low;
    } apdb_cmd_t;

endpackage : apdb_pkg

// ===== rtl/apdb_edge_flag.sv
// sticky flag: set by a hardware event, cleared by writing one; set wins
// assumes set and clear are one-cycle synchronous pulses
`timescale 1ns/100ps
module apdb_edge_flag (
    input wire logic clk,
    input wire logic resetn,
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);
    // set takes precedence so an event in the clearing cycle survives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule : apdb_edge_flag

// ===== rtl/apdb_bridge.sv
// atapi packet doorbell bridge: turns packet commands into pio setup and status fises
// assumes the stp target moves fis payloads and reports the end of each data-in chunk
`timescale 1ns/100ps
module apdb_bridge #(
    parameter int DB_WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RESETN,
    // issued packet command from the host side
    input wire logic CMD_VALID,
    input wire apdb_pkg::apdb_cmd_t CMD,
    // command block received from the host
    input wire logic CDB_DONE,
    // data-in chunk fully moved to the host
    input wire logic CHUNK_SENT,
    // fis request toward the stp target
    output logic FIS_VALID,
    input wire logic FIS_READY,
    output apdb_pkg::apdb_fis_t FIS,
    // processor register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic IRQ
);

    // ****************************************************************
    // state machine
    // ****************************************************************
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_CDB_FIS = 7'b000_0010,
        ST_CDB_WAIT = 7'b000_0100,
        ST_WAIT_DB = 7'b000_1000,
        ST_DATA_FIS = 7'b001_0000,
        ST_DATA_WAIT = 7'b010_0000,
        ST_STATUS_FIS = 7'b100_0000
    } apdb_state_t;

    apdb_state_t state_q;
    apdb_state_t state_d;

    logic [DB_WIDTH-1:0] tgt_db_q;
    logic [DB_WIDTH-1:0] proc_db_q;
    logic [7:0] tgt_len_q;
    logic [7:0] proc_len_q;
    logic [1:0] attr_q;
    logic [15:0] limit_q;
    logic [2:0] irq_mask_q;
    wire [2:0] irq_status;
    logic [7:0] rdata_q;
    logic fis_valid_q;
    apdb_pkg::apdb_fis_t fis_q;

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire wr_tgt_db = REG_WR && (REG_ADDR == apdb_pkg::ADDR_TARGET_DOORBELL);
    wire wr_proc_db = REG_WR && (REG_ADDR == apdb_pkg::ADDR_PROCESSOR_DOORBELL);
    wire wr_proc_len = REG_WR && (REG_ADDR == apdb_pkg::ADDR_PROCESSOR_CHUNK_LENGTH);
    wire wr_attr = REG_WR && (REG_ADDR == apdb_pkg::ADDR_CHUNK_ATTRIBUTES);
    wire wr_irq_stat = REG_WR && (REG_ADDR == apdb_pkg::ADDR_IRQ_STATUS);
    wire wr_irq_mask = REG_WR && (REG_ADDR == apdb_pkg::ADDR_IRQ_MASK);

    // host byte limit from the issued command
    wire [15:0] cmd_limit = {CMD.cyl_high, CMD.cyl_low};
    wire cmd_take = CMD_VALID && (state_q == ST_IDLE);
    wire fis_done = fis_valid_q && FIS_READY;
    wire last_chunk = (attr_q == apdb_pkg::ATTR_LAST_IN);
    // processor rang either the packet or the read doorbell, whichever chunk is being awaited
    wire ack_seen = proc_db_q[apdb_pkg::DB_PACKET_BIT] || proc_db_q[apdb_pkg::DB_READ_BIT];
    // dword count 0 stands for 256 dwords, so widen before scaling to bytes
    wire [8:0] chunk_dwords = (proc_len_q == 8'h00) ? 9'h100 : {1'b0, proc_len_q};
    wire [15:0] chunk_bytes = {5'h00, chunk_dwords, 2'b00};
    wire sent_event = CHUNK_SENT && (state_q == ST_DATA_WAIT);

    // ****************************************************************
    // sticky interrupt events: packet received, chunk sent, command done
    // ****************************************************************
    wire [2:0] irq_set = {fis_done && (state_q == ST_STATUS_FIS), sent_event, cmd_take};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_irq
            apdb_edge_flag u_flag (
                .clk(CLK),
                .resetn(RESETN),
                .set(irq_set[gi]),
                .clr(wr_irq_stat && REG_WDATA[gi]),
                .flag_q(irq_status[gi])
            );
        end
    endgenerate

    assign IRQ = |(irq_status & irq_mask_q);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (CMD_VALID) begin
                    state_d = ST_CDB_FIS;
                end
            end
            ST_CDB_FIS: begin
                if (fis_done) begin
                    state_d = ST_CDB_WAIT;
                end
            end
            ST_CDB_WAIT: begin
                if (CDB_DONE) begin
                    state_d = ST_WAIT_DB;
                end
            end
            ST_WAIT_DB: begin
                if (ack_seen) begin
                    state_d = ST_DATA_FIS;
                end
            end
            ST_DATA_FIS: begin
                if (fis_done) begin
                    state_d = ST_DATA_WAIT;
                end
            end
            ST_DATA_WAIT: begin
                if (CHUNK_SENT) begin
                    state_d = last_chunk ? ST_STATUS_FIS : ST_WAIT_DB;
                end
            end
            ST_STATUS_FIS: begin
                if (fis_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // target doorbell and target chunk length
    // ****************************************************************
    // hardware sets win over a software clear in the same cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tgt_db_q <= DB_WIDTH'(apdb_pkg::DOORBELL_RESET);
            tgt_len_q <= apdb_pkg::CHUNK_LEN_FULL;
            limit_q <= 16'h0000;
        end else begin
            if (wr_tgt_db) begin
                tgt_db_q <= REG_WDATA[DB_WIDTH-1:0];
            end
            if (cmd_take) begin
                limit_q <= cmd_limit;
                tgt_db_q[apdb_pkg::DB_PACKET_BIT] <= 1'b1;
                if (cmd_limit == apdb_pkg::LIMIT_SMALL) begin
                    tgt_len_q <= apdb_pkg::CHUNK_LEN_HALF;
                end else if (cmd_limit > apdb_pkg::LIMIT_LARGE) begin
                    tgt_len_q <= apdb_pkg::CHUNK_LEN_FULL;
                end
            end
            if (sent_event) begin
                tgt_db_q[apdb_pkg::DB_READ_BIT] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // processor side registers
    // ****************************************************************
    // the processor doorbell is consumed when the data-in fis starts, so one ring is one chunk
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            proc_db_q <= DB_WIDTH'(apdb_pkg::DOORBELL_RESET);
            proc_len_q <= apdb_pkg::CHUNK_LEN_FULL;
            attr_q <= 2'b00;
            irq_mask_q <= apdb_pkg::IRQ_MASK_RESET;
        end else begin
            if (wr_proc_db) begin
                proc_db_q <= REG_WDATA[DB_WIDTH-1:0];
            end else if (state_q == ST_WAIT_DB && ack_seen) begin
                proc_db_q[apdb_pkg::DB_PACKET_BIT] <= 1'b0;
                proc_db_q[apdb_pkg::DB_READ_BIT] <= 1'b0;
            end
            if (wr_proc_len) begin
                proc_len_q <= REG_WDATA;
            end
            if (wr_attr) begin
                attr_q <= REG_WDATA[1:0];
            end
            if (wr_irq_mask) begin
                irq_mask_q <= REG_WDATA[2:0];
            end
        end
    end

    // ****************************************************************
    // fis generation
    // ****************************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fis_valid_q <= 1'b0;
            fis_q <= '0;
        end else if (fis_done) begin
            fis_valid_q <= 1'b0;
        end else if (!fis_valid_q) begin
            if (state_q == ST_CDB_FIS) begin
                fis_valid_q <= 1'b1;
                fis_q.kind <= apdb_pkg::FIS_PIO_SETUP;
                fis_q.dir_in <= 1'b0;
                fis_q.irq <= 1'b0;
                fis_q.initial_status <= apdb_pkg::ST_DRDY | apdb_pkg::ST_DRQ;
                fis_q.ending_status <= apdb_pkg::ST_BSY | apdb_pkg::ST_DRDY;
                fis_q.error <= apdb_pkg::ERROR_NONE;
                fis_q.pio_byte_count <= apdb_pkg::CDB_BYTE_COUNT;
            end else if (state_q == ST_DATA_FIS) begin
                fis_valid_q <= 1'b1;
                fis_q.kind <= apdb_pkg::FIS_PIO_SETUP;
                fis_q.dir_in <= 1'b1;
                fis_q.irq <= 1'b1;
                fis_q.initial_status <= apdb_pkg::ST_DRDY | apdb_pkg::ST_DRQ;
                fis_q.ending_status <= apdb_pkg::ST_BSY | apdb_pkg::ST_DRDY;
                fis_q.error <= apdb_pkg::ERROR_NONE;
                fis_q.pio_byte_count <= chunk_bytes;
            end else if (state_q == ST_STATUS_FIS) begin
                fis_valid_q <= 1'b1;
                fis_q.kind <= apdb_pkg::FIS_REG_D2H;
                fis_q.dir_in <= 1'b0;
                fis_q.irq <= 1'b1;
                fis_q.initial_status <= apdb_pkg::ST_DRDY;
                fis_q.ending_status <= apdb_pkg::ST_DRDY;
                fis_q.error <= apdb_pkg::ERROR_NONE;
                fis_q.pio_byte_count <= 16'h0000;
            end
        end
    end

    assign FIS_VALID = fis_valid_q;
    assign FIS = fis_q;

    // ****************************************************************
    // read data, one cycle after the read strobe; unmapped reads zero
    // ****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (REG_ADDR)
            apdb_pkg::ADDR_TARGET_DOORBELL: rd_mux = 8'(tgt_db_q);
            apdb_pkg::ADDR_PROCESSOR_DOORBELL: rd_mux = 8'(proc_db_q);
            apdb_pkg::ADDR_TARGET_CHUNK_LENGTH: rd_mux = tgt_len_q;
            apdb_pkg::ADDR_PROCESSOR_CHUNK_LENGTH: rd_mux = proc_len_q;
            apdb_pkg::ADDR_CHUNK_ATTRIBUTES: rd_mux = {6'h00, attr_q};
            apdb_pkg::ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_status};
            apdb_pkg::ADDR_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
            apdb_pkg::ADDR_HOST_BYTE_LIMIT: rd_mux = limit_q[15:8];
            apdb_pkg::ADDR_BRIDGE_STATE: rd_mux = {1'b0, state_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 8'h00;
        end else if (REG_RD) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign REG_RDATA = rdata_q;

endmodule : apdb_bridge

// ===== test/apdb_bridge_assertions.sv
// concurrent checks on the packet doorbell bridge ports
// assumes one clock domain and the async active-low reset of the bridge
`timescale 1ns/100ps
module apdb_bridge_assertions (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CMD_VALID,
    input wire apdb_pkg::apdb_cmd_t CMD,
    input wire logic CDB_DONE,
    input wire logic CHUNK_SENT,
    input wire logic FIS_VALID,
    input wire logic FIS_READY,
    input wire apdb_pkg::apdb_fis_t FIS,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic IRQ
);
    // ********************
    // helper state
    // ********************
    logic busy_q;
    logic bell_q;
    wire pio = FIS.kind == apdb_pkg::FIS_PIO_SETUP;
    wire take = FIS_VALID && FIS_READY;
    wire ring = REG_WR && REG_ADDR == apdb_pkg::ADDR_PROCESSOR_DOORBELL && (REG_WDATA[0] || REG_WDATA[4]);

    // busy spans a command up to its status fis; bell spans a ring up to the data fis it allows
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_q <= 1'b0;
            bell_q <= 1'b0;
        end else begin
            busy_q <= (busy_q || CMD_VALID) && !(take && !pio);
            bell_q <= ring || (bell_q && !(take && pio && FIS.dir_in));
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    // ********************
    // assertions
    // ********************
    a_fis_holds: assert property (FIS_VALID && !FIS_READY |=> FIS_VALID && $stable(FIS))
        else $error("fis changed before it was taken");
    a_pio_status: assert property (FIS_VALID && pio |->
        FIS.initial_status == 8'h48 && FIS.ending_status == 8'hC0)
        else $error("pio setup status wrong");
    a_cdb_form: assert property (FIS_VALID && pio && !FIS.dir_in |-> !FIS.irq && FIS.pio_byte_count == 16'h000C)
        else $error("command block fis wrong");
    a_data_form: assert property (FIS_VALID && pio && FIS.dir_in |-> FIS.irq &&
        FIS.pio_byte_count[1:0] == 2'h0 && FIS.pio_byte_count != 16'h0000 && FIS.pio_byte_count <= 16'h0400)
        else $error("data fis wrong");
    a_status_form: assert property (FIS_VALID && !pio |-> FIS.irq && FIS.error == 8'h00 &&
        (FIS.initial_status & 8'hC9) == 8'h40)
        else $error("status fis wrong");
    a_cmd_opens: assert property (CMD_VALID && !busy_q |-> ##[1:3] (FIS_VALID && pio && !FIS.dir_in))
        else $error("no command block fis after command");
    a_data_waits: assert property ($rose(FIS_VALID) && pio && FIS.dir_in |-> bell_q)
        else $error("data fis before doorbell");
    a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside read slot");
    a_unmapped: assert property (REG_RD && REG_ADDR > 4'h8 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (REG_WR && REG_ADDR == apdb_pkg::ADDR_IRQ_MASK && REG_WDATA == 8'h00 |-> ##2 !IRQ)
        else $error("irq with all masked");

    c_command: cover property (CMD_VALID && !busy_q);
    c_data: cover property (take && pio && FIS.dir_in);
    c_status: cover property (take && !pio);
endmodule : apdb_bridge_assertions

// ===== test/apdb_host_model.sv
// host side model: takes fises, reports command block and chunk completion
// assumes the bridge holds a fis request until it is taken
`timescale 1ns/100ps
module apdb_host_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic fis_valid,
    input wire apdb_pkg::apdb_fis_t fis,
    output logic fis_ready,
    output logic cdb_done,
    output logic chunk_sent,
    output apdb_pkg::apdb_fis_t got,
    output logic [7:0] got_cnt
);
    logic [3:0] stall_q;
    logic [3:0] tail_q;
    logic tail_in_q;
    wire take = fis_valid && fis_ready;

    // slow mode stalls three cycles per fis; the transfer itself ends a few cycles after the take
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fis_ready <= 1'b0;
            cdb_done <= 1'b0;
            chunk_sent <= 1'b0;
            got <= '0;
            got_cnt <= 8'h00;
            stall_q <= 4'h0;
            tail_q <= 4'h0;
            tail_in_q <= 1'b0;
        end else begin
            fis_ready <= fis_valid && !take && (!slow || stall_q == 4'h3);
            stall_q <= take ? 4'h0 : ((fis_valid && stall_q != 4'h3) ? stall_q + 4'h1 : stall_q);
            tail_q <= (take && fis.kind == apdb_pkg::FIS_PIO_SETUP) ? 4'h6 : ((tail_q != 4'h0) ? tail_q - 4'h1 : 4'h0);
            cdb_done <= tail_q == 4'h1 && !tail_in_q;
            chunk_sent <= tail_q == 4'h1 && tail_in_q;
            if (take) begin
                got <= fis;
                got_cnt <= got_cnt + 8'h01;
                tail_in_q <= fis.dir_in;
            end
        end
    end
endmodule : apdb_host_model

// ===== test/testbench.sv
// testbench for the packet doorbell bridge: the bench plays the processor
// assumes the host model in apdb_host_model.sv answers the fis port
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk;
    logic resetn;
    logic cmd_valid;
    apdb_pkg::apdb_cmd_t cmd;
    logic cdb_done;
    logic chunk_sent;
    logic fis_valid;
    logic fis_ready;
    apdb_pkg::apdb_fis_t fis;
    apdb_pkg::apdb_fis_t got;
    logic [7:0] got_cnt;
    logic [7:0] exp_cnt;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic irq;
    logic slow;
    int failures;
    int total_checks;

    apdb_bridge i_dut (.CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD(cmd), .CDB_DONE(cdb_done),
        .CHUNK_SENT(chunk_sent), .FIS_VALID(fis_valid), .FIS_READY(fis_ready), .FIS(fis), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq));
    apdb_host_model i_host (.clk(clk), .resetn(resetn), .slow(slow), .fis_valid(fis_valid), .fis(fis),
        .fis_ready(fis_ready), .cdb_done(cdb_done), .chunk_sent(chunk_sent), .got(got), .got_cnt(got_cnt));

    // 25 MHz clock
    always #20 clk = ~clk;

    // ********************
    // bus tasks
    // ********************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic wait_fis;
        int k;
        k = 0;
        while (got_cnt == exp_cnt && k < 300) begin
            @(posedge clk);
            k++;
        end
        @(negedge clk);
        `CHK("fis_seen", exp_cnt + 8'h01, got_cnt)
        exp_cnt = exp_cnt + 8'h01;
    endtask : wait_fis

    function automatic apdb_pkg::apdb_fis_t mk(input logic din, input logic [15:0] cnt);
        mk = '{kind: apdb_pkg::FIS_PIO_SETUP, dir_in: din, irq: din, initial_status: 8'h48,
            ending_status: 8'hC0, error: 8'h00, pio_byte_count: cnt};
    endfunction : mk

    // ********************
    // scenarios
    // ********************
    // one whole packet command; attributes mark the last chunk
    task automatic run_cmd(input logic [15:0] lim, input logic [7:0] tcl, input int n,
        input logic [7:0] l0, input logic [7:0] l1);
        logic [7:0] d;
        logic [7:0] len;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{cyl_high: lim[15:8], cyl_low: lim[7:0]};
        @(posedge clk);
        cmd_valid <= 1'b0;
        rd(apdb_pkg::ADDR_TARGET_DOORBELL, d);
        `CHK("pkt_bell", 1'b1, d[0])
        rd(apdb_pkg::ADDR_TARGET_CHUNK_LENGTH, d);
        `CHK("tgt_len", tcl, d)
        rd(apdb_pkg::ADDR_HOST_BYTE_LIMIT, d);
        `CHK("limit_hi", lim[15:8], d)
        wait_fis();
        `CHK("cdb_fis", mk(1'b0, 16'h000C), got)
        repeat (12) @(posedge clk);
        `CHK("early_fis", exp_cnt, got_cnt)
        wr(apdb_pkg::ADDR_TARGET_DOORBELL, 8'h00);
        for (int i = 0; i < n; i++) begin
            len = (i == 0) ? l0 : l1;
            wr(apdb_pkg::ADDR_PROCESSOR_CHUNK_LENGTH, len);
            wr(apdb_pkg::ADDR_CHUNK_ATTRIBUTES, (i == n - 1) ? 8'h03 : 8'h01);
            wr(apdb_pkg::ADDR_PROCESSOR_DOORBELL, (i == 0) ? 8'h01 : 8'h10);
            wait_fis();
            `CHK("data_fis", mk(1'b1, (len == 8'h00) ? 16'h0400 : {6'h00, len, 2'h0}), got)
            repeat (12) @(posedge clk);
            rd(apdb_pkg::ADDR_TARGET_DOORBELL, d);
            `CHK("sent_bell", 1'b1, d[4])
            wr(apdb_pkg::ADDR_TARGET_DOORBELL, 8'h00);
        end
        wait_fis();
        `CHK("d2h_kind", apdb_pkg::FIS_REG_D2H, got.kind)
        `CHK("d2h_err", 8'h00, got.error)
        `CHK("d2h_irq", 1'b1, got.irq)
        `CHK("d2h_stat", 8'h40, got.initial_status)
    endtask : run_cmd

    // events latch in status; the line follows status and mask
    task automatic irq_check;
        logic [7:0] d;
        `CHK("irq_masked", 1'b0, irq)
        rd(apdb_pkg::ADDR_IRQ_STATUS, d);
        `CHK("irq_stat", 8'h07, d)
        wr(apdb_pkg::ADDR_IRQ_MASK, 8'h04);
        settle();
        `CHK("irq_on", 1'b1, irq)
        wr(apdb_pkg::ADDR_IRQ_MASK, 8'h00);
        settle();
        `CHK("irq_off", 1'b0, irq)
        wr(apdb_pkg::ADDR_IRQ_MASK, 8'h02);
        wr(apdb_pkg::ADDR_IRQ_STATUS, 8'h02);
        settle();
        `CHK("irq_clr", 1'b0, irq)
        rd(apdb_pkg::ADDR_IRQ_STATUS, d);
        `CHK("irq_left", 8'h05, d)
        wr(apdb_pkg::ADDR_IRQ_STATUS, 8'h05);
        rd(4'hF, d);
        `CHK("unmapped", 8'h00, d)
    endtask : irq_check

    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        slow = 1'b0;
        exp_cnt = 8'h00;
        failures = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        run_cmd(16'h0800, 8'h00, 1, 8'h05, 8'h00);
        irq_check();
        run_cmd(16'h0200, 8'h80, 2, 8'h80, 8'h48);
        @(posedge clk);
        slow <= 1'b1;
        run_cmd(16'h0401, 8'h00, 2, 8'h00, 8'h80);
        close_out();
    end

    // watchdog: whole run needs well under 5000 cycles
    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule : testbench

bind apdb_bridge apdb_bridge_assertions i_chk (.CLK(CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CDB_DONE(CDB_DONE), .CHUNK_SENT(CHUNK_SENT), .FIS_VALID(FIS_VALID), .FIS_READY(FIS_READY), .FIS(FIS),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
